// >>> src/sradr_core.v
`timescale 1ns/10ps
`include "sradr_defines.vh"
module sradr_core (
	// Clock and reset
	input wire clk_in,
	input wire resetn_in,
	// Serial link pins
	input wire chip_select_n_in,
	input wire sclk_in,
	input wire sdi_in,
	output reg sdo_out,
	output reg sdo_oe_out,
	output reg gpio6_out,
	output reg gpio6_oe_out,
	// Converter side
	input wire [23:0] result_in,
	input wire result_valid_in
);
	localparam ST_INST = 2'h0;
	localparam ST_UAB = 2'h1;
	localparam ST_DATA = 2'h2;
	localparam PULSE_CYC = (`SRADR_READY_PULSE_NS + `SRADR_CLK_PERIOD_NS - 1)
		/ `SRADR_CLK_PERIOD_NS;
	localparam [3:0] PULSE_LOAD = PULSE_CYC[3:0];

	wire [2:0] pins_s;
	wire cs_n_s;
	wire sclk_s;
	wire sdi_s;
	reg sclk_prev_q;

	sradr_sync #(.W(3)) u_sync (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.async_in({chip_select_n_in, sclk_in, sdi_in}),
		.sync_out(pins_s)
	);
	assign cs_n_s = pins_s[2];
	assign sclk_s = pins_s[1];
	assign sdi_s = pins_s[0];

	wire sel = ~cs_n_s;
	wire rise = sel & sclk_s & ~sclk_prev_q;
	wire fall = sel & ~sclk_s & sclk_prev_q;

	// Protocol state
	reg [1:0] state_q;
	reg [2:0] bit_cnt_q;
	reg [7:0] rx_q;
	reg [7:0] tx_q;
	reg sdo_bit_q;
	reg reading_q;
	reg ua_read_q;
	reg [2:0] upper_addr_q;
	reg [6:0] cur_addr_q;
	reg [6:0] start_addr_q;
	reg [2:0] span_cnt_q;
	reg stream_q;
	reg stream_ctl_q;
	reg [1:0] left_q;
	reg [6:0] ones_cnt_q;
	reg snap_hold_q;
	reg [23:0] snap_q;
	reg lsb_evt_q;
	reg fresh_clr_q;
	reg wr_req_q;
	reg [6:0] wr_addr_q;
	reg [7:0] wr_data_q;

	// Register storage and result side
	reg [7:0] regs_q [0:`SRADR_REG_COUNT-1];
	reg [23:0] result_q;
	reg fresh_n_q;
	reg data_ready_n_q;
	reg [3:0] pulse_cnt_q;

	wire [7:0] rx_d = {rx_q[6:0], sdi_s};
	wire [7:0] strm_ctl = regs_q[`SRADR_ADDR_STRM_CTL];
	wire [7:0] pin_ctl = regs_q[`SRADR_ADDR_PIN_CTL];
	wire stream_kind = strm_ctl[`SRADR_STRM_KIND_BIT];
	wire [2:0] stream_span = strm_ctl[`SRADR_STRM_SPAN_MSB:`SRADR_STRM_SPAN_LSB];
	wire [2:0] pin_drive_select = pin_ctl[`SRADR_PIN_SEL_MSB:`SRADR_PIN_SEL_LSB];
	wire ready_on_gpio6 = pin_ctl[`SRADR_GPIO6_RDY_BIT];
	wire prst_en = (regs_q[`SRADR_ADDR_PRST_EN] == `SRADR_PRST_ON_VAL);
	wire prst_fire = prst_en & rise & sdi_s
		& (ones_cnt_q >= (`SRADR_PRST_ONES - 7'h01));

	// Address step: wrap to start in controlled mode, 7-bit roll-over otherwise
	wire span_end = stream_ctl_q & (span_cnt_q == stream_span);
	wire [6:0] adv_addr = span_end ? start_addr_q : cur_addr_q + 7'h01;
	wire [6:0] first_addr = {upper_addr_q, rx_d[3:0]};
	wire [6:0] lk_addr = (state_q == ST_INST) ? first_addr : adv_addr;
	wire read_only = (wr_addr_q == `SRADR_ADDR_STATUS)
		| (wr_addr_q == `SRADR_ADDR_RES_H)
		| (wr_addr_q == `SRADR_ADDR_RES_M)
		| (wr_addr_q == `SRADR_ADDR_RES_L);
	wire soft_rst = wr_req_q & (wr_addr_q == `SRADR_ADDR_SOFT_RST)
		& (wr_data_q == `SRADR_SOFT_RST_VAL);

	reg [7:0] lk_data;
	always @* begin
		if (lk_addr == `SRADR_ADDR_RES_H) begin
			lk_data = result_q[23:16];
		end else if (lk_addr == `SRADR_ADDR_RES_M) begin
			lk_data = snap_hold_q ? snap_q[15:8] : result_q[15:8];
		end else if (lk_addr == `SRADR_ADDR_RES_L) begin
			lk_data = snap_hold_q ? snap_q[7:0] : result_q[7:0];
		end else if (lk_addr == `SRADR_ADDR_STATUS) begin
			lk_data = 8'h00;
			lk_data[`SRADR_FRESH_BIT] = fresh_n_q;
		end else begin
			lk_data = regs_q[lk_addr];
		end
	end

	// Serial protocol engine on sampled link clock edges
	always @(posedge clk_in) begin
		if (!resetn_in) begin
			sclk_prev_q <= 1'b1;
			state_q <= ST_INST;
			bit_cnt_q <= 3'h0;
			rx_q <= 8'h00;
			tx_q <= 8'h00;
			sdo_bit_q <= 1'b1;
			reading_q <= 1'b0;
			ua_read_q <= 1'b0;
			upper_addr_q <= `SRADR_UA_RST;
			cur_addr_q <= 7'h00;
			start_addr_q <= 7'h00;
			span_cnt_q <= 3'h0;
			stream_q <= 1'b0;
			stream_ctl_q <= 1'b0;
			left_q <= 2'h0;
			ones_cnt_q <= 7'h00;
			snap_hold_q <= 1'b0;
			snap_q <= 24'h000000;
			lsb_evt_q <= 1'b0;
			fresh_clr_q <= 1'b0;
			wr_req_q <= 1'b0;
			wr_addr_q <= 7'h00;
			wr_data_q <= 8'h00;
		end else begin
			sclk_prev_q <= sclk_s;
			lsb_evt_q <= 1'b0;
			fresh_clr_q <= 1'b0;
			wr_req_q <= 1'b0;
			if (!sel) begin
				// Deselect ends any transaction
				state_q <= ST_INST;
				bit_cnt_q <= 3'h0;
				reading_q <= 1'b0;
				snap_hold_q <= 1'b0;
				// Deselect breaks a run of ones
				ones_cnt_q <= 7'h00;
				sdo_bit_q <= 1'b1;
			end else if (rise) begin
				if (sdi_s && ones_cnt_q != `SRADR_PRST_ONES) begin
					ones_cnt_q <= ones_cnt_q + 7'h01;
				end else if (!sdi_s) begin
					ones_cnt_q <= 7'h00;
				end
				rx_q <= rx_d;
				bit_cnt_q <= bit_cnt_q + 3'h1;
				if (prst_fire) begin
					// Hold at instruction start until a zero opens a write
					state_q <= ST_INST;
					bit_cnt_q <= 3'h0;
					reading_q <= 1'b0;
					upper_addr_q <= `SRADR_UA_RST;
				end else if (bit_cnt_q == 3'h7) begin
					case (state_q)
					ST_INST: begin
						if (rx_d == `SRADR_INST_UA_WR) begin
							state_q <= ST_UAB;
							ua_read_q <= 1'b0;
						end else if (rx_d == `SRADR_INST_UA_RD) begin
							state_q <= ST_UAB;
							ua_read_q <= 1'b1;
							reading_q <= 1'b1;
							tx_q <= {5'h00, upper_addr_q};
						end else begin
							state_q <= ST_DATA;
							cur_addr_q <= first_addr;
							start_addr_q <= first_addr;
							span_cnt_q <= 3'h0;
							stream_q <= (rx_d[6:5] == `SRADR_SZ_STREAM);
							stream_ctl_q <= (rx_d[6:5] == `SRADR_SZ_STREAM) & stream_kind;
							left_q <= (rx_d[6:5] == `SRADR_SZ_ONE) ? 2'h1 : 2'h2;
							reading_q <= rx_d[`SRADR_RW_BIT];
							tx_q <= lk_data;
							if (rx_d[`SRADR_RW_BIT] && first_addr == `SRADR_ADDR_RES_H) begin
								snap_q <= result_q;
								snap_hold_q <= 1'b1;
							end
						end
					end
					ST_UAB: begin
						if (!ua_read_q) begin
							upper_addr_q <= rx_d[2:0];
						end
						state_q <= ST_INST;
						reading_q <= 1'b0;
					end
					default: begin
						if (!reading_q) begin
							wr_req_q <= 1'b1;
							wr_addr_q <= cur_addr_q;
							wr_data_q <= rx_d;
						end else if (cur_addr_q == `SRADR_ADDR_RES_L) begin
							lsb_evt_q <= 1'b1;
						end
						if (!stream_q && left_q == 2'h1) begin
							state_q <= ST_INST;
							reading_q <= 1'b0;
						end else begin
							left_q <= left_q - 2'h1;
							cur_addr_q <= adv_addr;
							span_cnt_q <= span_end ? 3'h0 : span_cnt_q + 3'h1;
							if (reading_q) begin
								tx_q <= lk_data;
								if (adv_addr == `SRADR_ADDR_RES_H) begin
									snap_q <= result_q;
									snap_hold_q <= 1'b1;
								end
							end
						end
					end
					endcase
				end
			end else if (fall && reading_q) begin
				sdo_bit_q <= tx_q[7];
				tx_q <= {tx_q[6:0], 1'b0};
				if (state_q == ST_DATA && bit_cnt_q == 3'h0
					&& cur_addr_q == `SRADR_ADDR_RES_H) begin
					fresh_clr_q <= 1'b1;
				end
			end
		end
	end

	// Register storage; protocol reset never touches it
	integer k;
	always @(posedge clk_in) begin
		if (!resetn_in || soft_rst) begin
			for (k = 0; k < `SRADR_REG_COUNT; k = k + 1) begin
				regs_q[k] <= `SRADR_REG_RST;
			end
		end else if (wr_req_q && !read_only) begin
			regs_q[wr_addr_q] <= wr_data_q;
		end
	end

	// Result holding, fresh flag and data ready timing
	always @(posedge clk_in) begin
		if (!resetn_in) begin
			result_q <= 24'h000000;
			fresh_n_q <= 1'b1;
			data_ready_n_q <= 1'b1;
			pulse_cnt_q <= 4'h0;
		end else begin
			if (result_valid_in) begin
				result_q <= result_in;
				fresh_n_q <= 1'b0;
			end else if (fresh_clr_q) begin
				fresh_n_q <= 1'b1;
			end
			if (result_valid_in) begin
				if (!data_ready_n_q && !snap_hold_q) begin
					data_ready_n_q <= 1'b1;
					pulse_cnt_q <= PULSE_LOAD;
				end else begin
					data_ready_n_q <= 1'b0;
					pulse_cnt_q <= 4'h0;
				end
			end else if (pulse_cnt_q != 4'h0) begin
				pulse_cnt_q <= pulse_cnt_q - 4'h1;
				if (pulse_cnt_q == 4'h1) begin
					data_ready_n_q <= 1'b0;
				end
			end else if (lsb_evt_q) begin
				data_ready_n_q <= 1'b1;
			end
		end
	end

	// Pin drive schemes
	reg sdo_d;
	reg sdo_oe_d;
	reg gpio6_d;
	reg gpio6_oe_d;
	always @* begin
		sdo_d = (sel && reading_q) ? sdo_bit_q : data_ready_n_q;
		sdo_oe_d = sel;
		gpio6_d = 1'b1;
		gpio6_oe_d = 1'b0;
		if (pin_drive_select == `SRADR_DRV_FREE) begin
			sdo_oe_d = 1'b1;
		end else if (pin_drive_select == `SRADR_DRV_GPIO6 && ready_on_gpio6) begin
			sdo_d = reading_q ? sdo_bit_q : 1'b1;
			gpio6_d = data_ready_n_q;
			gpio6_oe_d = 1'b1;
		end
	end

	always @(posedge clk_in) begin
		if (!resetn_in) begin
			sdo_out <= 1'b1;
			sdo_oe_out <= 1'b0;
			gpio6_out <= 1'b1;
			gpio6_oe_out <= 1'b0;
		end else begin
			sdo_out <= sdo_d;
			sdo_oe_out <= sdo_oe_d;
			gpio6_out <= gpio6_d;
			gpio6_oe_out <= gpio6_oe_d;
		end
	end
endmodule

// >>> src/sradr_defines.vh
`ifndef SRADR_DEFINES_VH
`define SRADR_DEFINES_VH

// Register addresses, seven bits: upper part [6:4], lower part [3:0]
`define SRADR_ADDR_W 7
`define SRADR_ADDR_SOFT_RST 7'h00
`define SRADR_ADDR_PRST_EN 7'h02
`define SRADR_ADDR_STRM_CTL 7'h03
`define SRADR_ADDR_PIN_CTL 7'h11
`define SRADR_ADDR_STATUS 7'h18
`define SRADR_ADDR_RES_H 7'h1A
`define SRADR_ADDR_RES_M 7'h1B
`define SRADR_ADDR_RES_L 7'h1C
`define SRADR_ADDR_TOP 7'h7F
`define SRADR_REG_COUNT 128

// Register reset value and key data values
`define SRADR_REG_RST 8'h00
`define SRADR_SOFT_RST_VAL 8'hC3
`define SRADR_PRST_ON_VAL 8'h01

// Field positions
`define SRADR_STRM_KIND_BIT 7
`define SRADR_STRM_SPAN_MSB 2
`define SRADR_STRM_SPAN_LSB 0
`define SRADR_PIN_SEL_MSB 3
`define SRADR_PIN_SEL_LSB 1
`define SRADR_GPIO6_RDY_BIT 4
`define SRADR_FRESH_BIT 6

// Instruction encodings
`define SRADR_INST_UA_WR 8'h10
`define SRADR_INST_UA_RD 8'h90
`define SRADR_SZ_ONE 2'h0
`define SRADR_SZ_STREAM 2'h3
`define SRADR_RW_BIT 7
`define SRADR_UA_RST 3'h0

// Pin drive schemes
`define SRADR_DRV_SHARED 3'h0
`define SRADR_DRV_FREE 3'h3
`define SRADR_DRV_GPIO6 3'h4

// Protocol reset run length of ones
`define SRADR_PRST_ONES 7'h49

// Timing
`define SRADR_CLK_PERIOD_NS 100
`define SRADR_READY_PULSE_NS 400

`endif

// >>> src/sradr_sync.v
`timescale 1ns/10ps
module sradr_sync #(
	parameter W = 3
) (
	// Clock and reset
	input wire clk_in,
	input wire resetn_in,
	// Asynchronous inputs and synchronised outputs
	input wire [W-1:0] async_in,
	output wire [W-1:0] sync_out
);
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			reg meta_q;
			reg stable_q;
			always @(posedge clk_in) begin
				if (!resetn_in) begin
					meta_q <= 1'b1;
					stable_q <= 1'b1;
				end else begin
					meta_q <= async_in[i];
					stable_q <= meta_q;
				end
			end
			assign sync_out[i] = stable_q;
		end
	endgenerate
endmodule

// >>> testbench/sradr_checker.sv
`timescale 1ns/10ps
module sradr_checker (
	input wire clk_in,
	input wire resetn_in,
	input wire chip_select_n_in,
	input wire sclk_in,
	input wire sdo_out,
	input wire sdo_oe_out,
	input wire gpio6_out,
	input wire gpio6_oe_out,
	input wire result_valid_in
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	sequence s_pulse;
		##[1:3] $rose(gpio6_out) ##0 gpio6_out [*4] ##1 !gpio6_out;
	endsequence
	sequence s_idle_low;
		gpio6_oe_out && chip_select_n_in [*8] ##0 !gpio6_out && !result_valid_in;
	endsequence
	AST_RESET_OUT: assert property (disable iff (1'b0) !resetn_in |=>
		!sdo_oe_out && sdo_out && !gpio6_oe_out && gpio6_out) else $error("reset outputs");
	AST_GPIO_IDLE: assert property (!gpio6_oe_out |-> gpio6_out)
		else $error("gpio6 idle level");
	AST_SEL_DRIVES: assert property (!chip_select_n_in [*6] |-> sdo_oe_out)
		else $error("pin not driven while selected");
	AST_READY_FALL: assert property (gpio6_oe_out && result_valid_in |-> ##[1:8] !gpio6_out)
		else $error("ready did not fall");
	AST_READY_PULSE: assert property (gpio6_oe_out && !gpio6_out && chip_select_n_in
		&& result_valid_in |-> s_pulse) else $error("ready pulse wrong");
	AST_READY_HOLD: assert property (s_idle_low ##0 !$past(result_valid_in) |=> !gpio6_out)
		else $error("ready rose without read");
	AST_SDO_STILL: assert property ((gpio6_oe_out && !chip_select_n_in && sclk_in) [*6]
		|-> $stable(sdo_out)) else $error("sdo moved with clock high");
	AST_GPIO_KEEP: assert property (gpio6_oe_out && chip_select_n_in [*8]
		|-> $stable(gpio6_oe_out)) else $error("gpio6 enable changed");
endmodule

// >>> testbench/sradr_core_bench.sv
`timescale 1ns/10ps
module sradr_core_bench;
	logic clk_in;
	logic resetn_in;
	logic [23:0] result_in;
	logic result_valid_in;
	logic cs_n, sclk, sdi, sdo_hold;
	wire sdo_out, sdo_oe_out, gpio6_out, gpio6_oe_out;
	wire sdo_pin = sdo_oe_out ? sdo_out : ~sdo_hold;
	int n_mismatch = 0;
	int n_compared = 0;
	int cyc = 0;
	logic [7:0] wd [4];
	logic [7:0] rd [4];
	logic [7:0] r;
	logic [2:0] ua_now = 3'h0;
	// Address, write data, expected read
	logic [22:0] rows [4] = '{{7'h05, 8'hA5, 8'hA5}, {7'h7F, 8'h3C, 8'h3C},
		{7'h18, 8'hFF, 8'h40}, {7'h1A, 8'h77, 8'h00}};
	sradr_core dut_u (.clk_in(clk_in), .resetn_in(resetn_in), .chip_select_n_in(cs_n),
		.sclk_in(sclk), .sdi_in(sdi), .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out),
		.gpio6_out(gpio6_out), .gpio6_oe_out(gpio6_oe_out), .result_in(result_in),
		.result_valid_in(result_valid_in));
	sradr_host host_u (.clk_in(clk_in), .cs_n_out(cs_n), .sclk_out(sclk), .sdi_out(sdi),
		.sdo_in(sdo_pin));
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		if (sdo_oe_out)
			sdo_hold <= sdo_out;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			n_mismatch++;
			$display("Error %0t: got %h expected %h", $time, s, e);
		end
	endtask
	task automatic give_verdict();
		if (n_mismatch == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic acc(input logic [2:0] ua, input logic [7:0] i2, input int n);
		host_u.sel();
		if (ua != ua_now) begin
			host_u.xb(8'h10, r);
			host_u.xb({5'h0, ua}, r);
			ua_now = ua;
		end
		host_u.xb(i2, r);
		for (int k = 0; k < n; k++)
			host_u.xb(wd[k], rd[k]);
		host_u.dsel();
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		wd[0] = d;
		acc(a[6:4], {4'h0, a[3:0]}, 1);
	endtask
	task automatic rd1(input logic [6:0] a);
		acc(a[6:4], {4'h8, a[3:0]}, 1);
	endtask
	task automatic rua(input logic [2:0] e);
		host_u.sel();
		host_u.xb(8'h90, r);
		host_u.xb(8'h00, r);
		host_u.dsel();
		chk(r, {5'h0, e});
	endtask
	task automatic res(input logic [23:0] v);
		@(posedge clk_in);
		result_in <= v;
		result_valid_in <= 1'b1;
		@(posedge clk_in);
		result_valid_in <= 1'b0;
		repeat (4) @(posedge clk_in);
	endtask
	task automatic pin(input logic e);
		host_u.sel();
		chk(sdo_pin, e);
		host_u.dsel();
	endtask
	// Upper setup then a long run of ones
	task automatic burst(input logic [2:0] ua);
		host_u.sel();
		if (ua != ua_now) begin
			host_u.xb(8'h10, r);
			host_u.xb({5'h0, ua}, r);
			ua_now = ua;
		end
		repeat (10) host_u.xb(8'hFF, r);
		host_u.dsel();
	endtask
	initial begin
		resetn_in = 1'b0;
		result_in = 24'h0;
		result_valid_in = 1'b0;
		sdo_hold = 1'b0;
		repeat (3) @(posedge clk_in);
		chk(sdo_oe_out, 1'b0);
		chk(gpio6_out, 1'b1);
		resetn_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		foreach (rows[i]) begin
			wr(rows[i][22:16], rows[i][15:8]);
			rd1(rows[i][22:16]);
			chk(rd[0], rows[i][7:0]);
			rua(rows[i][22:20]);
		end
		chk(sdo_oe_out, 1'b0);
		wd = '{8'h11, 8'h22, 8'h33, 8'h00};
		acc(3'h7, 8'h6E, 3);
		rua(3'h7);
		acc(3'h7, 8'hEE, 3);
		chk({rd[0], rd[1], rd[2]}, 24'h112233);
		wr(7'h03, 8'h81);
		acc(3'h7, 8'hEE, 4);
		chk({rd[0], rd[1], rd[2], rd[3]}, 32'h11221122);
		wr(7'h03, 8'h82);
		res(24'h123456);
		rd1(7'h18);
		chk(rd[0], 8'h00);
		pin(1'b0);
		acc(3'h1, 8'hEA, 3);
		chk({rd[0], rd[1], rd[2]}, 24'h123456);
		pin(1'b1);
		rd1(7'h18);
		chk(rd[0], 8'h40);
		burst(3'h3);
		rua(3'h3);
		wr(7'h02, 8'h01);
		burst(3'h3);
		ua_now = 3'h0;
		rua(3'h0);
		rd1(7'h05);
		chk(rd[0], 8'hA5);
		res(24'h654321);
		wr(7'h00, 8'hC3);
		rd1(7'h18);
		chk(rd[0], 8'h00);
		wr(7'h11, 8'h06);
		chk(sdo_oe_out, 1'b1);
		wr(7'h11, 8'h18);
		chk(gpio6_oe_out, 1'b1);
		res(24'h0000AA);
		repeat (10) @(posedge clk_in);
		chk(gpio6_out, 1'b0);
		rd1(7'h18);
		chk(rd[0], 8'h00);
		give_verdict();
	end
endmodule
bind sradr_core sradr_checker chk_u (.clk_in, .resetn_in, .chip_select_n_in, .sclk_in,
	.sdo_out, .sdo_oe_out, .gpio6_out, .gpio6_oe_out, .result_valid_in);

// >>> testbench/sradr_host.sv
`timescale 1ns/10ps
module sradr_host (
	// Clock
	input wire clk_in,
	// Link pins
	output logic cs_n_out,
	output logic sclk_out,
	output logic sdi_out,
	input wire sdo_in
);
	initial begin
		cs_n_out = 1'b1;
		sclk_out = 1'b1;
		sdi_out = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	// Select, then give data ready time to show
	task automatic sel();
		cs_n_out <= 1'b0;
		wt(8);
	endtask
	task automatic dsel();
		cs_n_out <= 1'b1;
		wt(8);
	endtask
	// One byte MSB first, read bit taken late in high phase
	task automatic xb(input logic [7:0] b, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			sclk_out <= 1'b0;
			sdi_out <= b[i];
			wt(4);
			sclk_out <= 1'b1;
			wt(4);
			r[i] = sdo_in;
		end
	endtask
endmodule
